// [shared/qcd_pkg.sv]
// constants, types and shared decoding for the quad current dac serial load block
`default_nettype none
package qcd_pkg;
    // serial frame
    localparam int unsigned FRAME_BITS     = 24;
    localparam int unsigned FRAME_BITS_PEC = 32;
    localparam int unsigned CHK_BITS       = 8;
    localparam int unsigned CNT_W          = 6;
    localparam logic [5:0]  CNT_SAT        = 6'h21;
    localparam logic [5:0]  LEN_PLAIN      = 6'h18;
    localparam logic [5:0]  LEN_PEC        = 6'h20;
    // word fields
    localparam int unsigned CMD_MSB     = 23;
    localparam int unsigned CMD_LSB     = 21;
    localparam int unsigned CH_MSB      = 17;
    localparam int unsigned CH_LSB      = 16;
    localparam int unsigned DATA_MSB    = 15;
    localparam int unsigned RANGE_MSB   = 1;
    localparam int unsigned RANGE_LSB   = 0;
    localparam int unsigned CTRL_OE_BIT = 8;
    localparam logic [2:0]  CMD_DATA    = 3'h0;
    localparam logic [2:0]  CMD_CTRL    = 3'h1;
    // channels and code path
    localparam int unsigned NUM_CH   = 4;
    localparam int unsigned CODE_W   = 16;
    localparam int unsigned SEG_W    = 15;
    localparam int unsigned LAD_W    = 12;
    localparam int unsigned CUR_W    = 25;
    // output ranges
    localparam logic [1:0]  RANGE_0_20 = 2'h0;
    localparam logic [1:0]  RANGE_0_24 = 2'h1;
    localparam logic [1:0]  RANGE_4_20 = 2'h2;
    localparam logic [1:0]  RANGE_RST  = RANGE_0_20;
    localparam logic [15:0] CODE_RST   = 16'h0000;
    // currents in nA
    localparam logic [24:0] SPAN_20_NA  = 25'h1312D00;
    localparam logic [24:0] SPAN_24_NA  = 25'h16E3600;
    localparam logic [24:0] SPAN_16_NA  = 25'h0F42400;
    localparam logic [24:0] OFF_4_20_NA = 25'h03D0900;
    // power-on calibration wait
    localparam longint CAL_TIME_US = 100;
    localparam longint MCLK_HZ     = 25000000;
    localparam longint CAL_CYC_L   = (CAL_TIME_US * MCLK_HZ + 999999) / 1000000;
    localparam int unsigned CAL_W  = 12;
    localparam logic [11:0] CAL_CYCLES = 12'(CAL_CYC_L);

    typedef enum logic [1:0] {
        ST_CAL = 2'b01,
        ST_RUN = 2'b10
    } qcd_state_t;

    // thermometer decode of the four code msbs
    function automatic logic [14:0] qcd_therm(input logic [3:0] msb);
        logic [14:0] t;
        t = 15'h0000;
        for (int k = 0; k < 15; k++) begin
            t[k] = (32'(msb) > k);
        end
        return t;
    endfunction
endpackage
`default_nettype wire

// [hw/qcd_sync2.sv]
// two flip-flop level synchroniser
`timescale 1ns/10ps
`default_nettype none
module qcd_sync2 import qcd_pkg::*; #(
    parameter logic RST_VAL = 1'b0
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    // level in and out
    input  wire logic d,
    output var  logic q
);
    logic meta_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_r <= RST_VAL;
            q      <= RST_VAL;
        end else if (ce) begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule
`default_nettype wire

// [hw/qcd_codepath.sv]
// per channel code path: segment and ladder switches, output current
`timescale 1ns/10ps
`default_nettype none
module qcd_codepath import qcd_pkg::*; (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // active code and range
    input  wire logic [15:0] code,
    input  wire logic [1:0]  range_sel,
    // switch drives and current
    output var  logic [14:0] seg_sw,
    output var  logic [11:0] lad_sw,
    output var  logic [24:0] cur_na
);
    logic [24:0] span;
    logic [24:0] offs;
    logic [40:0] prod;

    always_comb begin
        case (range_sel)
            RANGE_0_24: begin
                span = SPAN_24_NA;
                offs = 25'h0000000;
            end
            RANGE_4_20: begin
                span = SPAN_16_NA;
                offs = OFF_4_20_NA;
            end
            default: begin
                span = SPAN_20_NA;
                offs = 25'h0000000;
            end
        endcase
    end

    // code is plain unsigned, no sign or offset coding
    assign prod = 41'(span) * 41'(code); // RQ7

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            seg_sw <= 15'h0000;
            lad_sw <= 12'h000;
            cur_na <= 25'h0000000;
        end else if (ce) begin
            seg_sw <= qcd_therm(code[15:12]); // RQ10
            lad_sw <= code[11:0]; // RQ11
            cur_na <= prod[40:16] + offs; // RQ13 RQ12
        end
    end
endmodule
`default_nettype wire

// [hw/qcd_serial_load.sv]
// serial load, update control and code paths of the quad current dac
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// RQ1 - frames are 24-bit words, shifted in msb first
// RQ2 - serial data is sampled on the falling serial clock edge
// RQ3 - with packet checking on, frames carry eight more bits, 32 in all
// RQ4 - strobe low: addressed channel updates when frame select rises
// RQ5 - strobe high: only first write per channel since strobe rose is applied
// RQ6 - strobe falling after frame select high updates all channels together
// RQ7 - codes are straight unsigned binary only
// RQ8 - current outputs are tristate after power-up
// RQ9 - host waits 100 us after reset before writing
// RQ10 - top four code bits drive fifteen segment switches as thermometer
// RQ11 - low twelve code bits drive the twelve ladder switches directly
// RQ12 - per channel range: 0-20 mA, 0-24 mA or 4-20 mA
// RQ13 - current is span times code over 2^16, plus 4 mA offset in 4-20
// RQ14 - frame starts with frame select low; clocks while high are ignored
module qcd_serial_load import qcd_pkg::*; (
    // system clock
    input  wire logic                    mclk,
    input  wire logic                    rst_n,
    input  wire logic                    ce,
    // serial link
    input  wire logic                    sclk,
    input  wire logic                    frame_sel_n,
    input  wire logic                    sdin,
    // update and mode pins
    input  wire logic                    output_update_strobe,
    input  wire logic                    packet_check,
    // status
    output var  logic                    cal_done,
    // channel outputs
    output var  logic [3:0]              channel_output_en,
    output var  logic [3:0][14:0]        segment_switches,
    output var  logic [3:0][11:0]        ladder_switches,
    output var  logic [3:0][24:0]        channel_current_output
);
    // link domain
    logic        first_r;
    logic [31:0] shift_r;
    logic [5:0]  cnt_r;

    // system domain
    logic             fsel_s;
    logic             strobe_s;
    logic             pec_s;
    logic             fsel_d_r;
    logic             strobe_d_r;
    logic             frame_end;
    logic             frame_ok;
    logic             strobe_rise;
    logic             strobe_fall;
    logic [23:0]      word;
    logic [2:0]       cmd;
    logic [1:0]       ch;
    logic [15:0]      din;
    logic             wr_data;
    logic             wr_ctrl;
    logic [3:0]       ch_hit;
    qcd_state_t       state_r;
    logic [11:0]      cal_cnt_r;
    logic [3:0][15:0] data_r;
    logic [3:0][15:0] pend_r;
    logic [3:0][15:0] active_r;
    logic [3:0]       taken_r;
    logic [3:0][1:0]  range_r;

    function automatic logic [3:0] ch_onehot(input logic [1:0] c);
        return 4'h1 << c;
    endfunction

    // frame select high rearms the bit counter; no sclk edge needed
    always_ff @(posedge frame_sel_n or negedge sclk) begin
        if (frame_sel_n) begin
            first_r <= 1'b1; // RQ14
        end else begin
            first_r <= 1'b0;
        end
    end

    always_ff @(negedge sclk) begin
        if (!frame_sel_n) begin
            shift_r <= {shift_r[30:0], sdin}; // RQ1 RQ2 RQ14
        end
    end

    always_ff @(negedge sclk) begin
        if (!frame_sel_n) begin
            if (first_r) begin
                cnt_r <= 6'h01;
            end else if (cnt_r != CNT_SAT) begin
                cnt_r <= cnt_r + 6'h01;
            end
        end
    end

    // pin inputs into the system clock domain
    qcd_sync2 #(.RST_VAL(1'b1)) u_sync_fsel (
        .clk   (mclk),
        .rst_n (rst_n),
        .ce    (ce),
        .d     (frame_sel_n),
        .q     (fsel_s)
    );

    qcd_sync2 #(.RST_VAL(1'b0)) u_sync_strobe (
        .clk   (mclk),
        .rst_n (rst_n),
        .ce    (ce),
        .d     (output_update_strobe),
        .q     (strobe_s)
    );

    qcd_sync2 #(.RST_VAL(1'b0)) u_sync_pec (
        .clk   (mclk),
        .rst_n (rst_n),
        .ce    (ce),
        .d     (packet_check),
        .q     (pec_s)
    );

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            fsel_d_r   <= 1'b1;
            strobe_d_r <= 1'b0;
        end else if (ce) begin
            fsel_d_r   <= fsel_s;
            strobe_d_r <= strobe_s;
        end
    end

    // shift_r and cnt_r are static once frame select is high again
    assign frame_end   = ce && fsel_s && !fsel_d_r;
    assign frame_ok    = frame_end && (state_r == ST_RUN) &&
                         (cnt_r == (pec_s ? LEN_PEC : LEN_PLAIN)); // RQ1 RQ3 RQ9
    assign word        = pec_s ? shift_r[31:8] : shift_r[23:0]; // RQ3
    assign cmd         = word[CMD_MSB:CMD_LSB];
    assign ch          = word[CH_MSB:CH_LSB];
    assign din         = word[DATA_MSB:0];
    assign wr_data     = frame_ok && (cmd == CMD_DATA);
    assign wr_ctrl     = frame_ok && (cmd == CMD_CTRL);
    assign ch_hit      = ch_onehot(ch);
    assign strobe_rise = ce && strobe_s && !strobe_d_r;
    assign strobe_fall = ce && !strobe_s && strobe_d_r;

    // frames are dropped until the calibration wait has run out
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_r   <= ST_CAL;
            cal_cnt_r <= 12'h000;
        end else if (ce) begin
            case (state_r)
                ST_CAL: begin
                    cal_cnt_r <= cal_cnt_r + 12'h001;
                    if (cal_cnt_r == CAL_CYCLES - 12'h001) begin
                        state_r <= ST_RUN; // RQ9
                    end
                end
                ST_RUN: begin
                    state_r <= ST_RUN;
                end
                default: begin
                    state_r <= ST_CAL;
                end
            endcase
        end
    end

    assign cal_done = (state_r == ST_RUN);

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
            // every write is stored, applied or not
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    data_r[gi] <= CODE_RST;
                end else if (wr_data && ch_hit[gi]) begin
                    data_r[gi] <= din; // RQ5
                end
            end

            // first write since the strobe rose claims the channel; set wins
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    taken_r[gi] <= 1'b0;
                end else if (wr_data && ch_hit[gi] && strobe_s) begin
                    taken_r[gi] <= 1'b1; // RQ5
                end else if (strobe_rise) begin
                    taken_r[gi] <= 1'b0;
                end
            end

            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    pend_r[gi] <= CODE_RST;
                end else if (wr_data && ch_hit[gi] && (!strobe_s || !taken_r[gi])) begin
                    pend_r[gi] <= din; // RQ5
                end
            end

            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    active_r[gi] <= CODE_RST;
                end else if (wr_data && ch_hit[gi] && !strobe_s) begin
                    active_r[gi] <= din; // RQ4
                end else if (strobe_fall) begin
                    active_r[gi] <= pend_r[gi]; // RQ6
                end
            end

            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    range_r[gi]           <= RANGE_RST;
                    channel_output_en[gi] <= 1'b0; // RQ8
                end else if (wr_ctrl && ch_hit[gi]) begin
                    range_r[gi]           <= word[RANGE_MSB:RANGE_LSB]; // RQ12
                    channel_output_en[gi] <= word[CTRL_OE_BIT];
                end
            end

            qcd_codepath u_path (
                .clk       (mclk),
                .rst_n     (rst_n),
                .ce        (ce),
                .code      (active_r[gi]),
                .range_sel (range_r[gi]),
                .seg_sw    (segment_switches[gi]),
                .lad_sw    (ladder_switches[gi]),
                .cur_na    (channel_current_output[gi])
            );
        end
    endgenerate

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    a_oe_after_reset: assert property ( // RQ8
        !$past(rst_n) |-> (channel_output_en == 4'h0) && !cal_done)
        else $error("outputs not tristate after reset");

    a_frame_length: assert property ( // RQ3
        wr_data |-> (pec_s ? cnt_r == 6'h20 : cnt_r == 6'h18))
        else $error("data write taken with wrong frame length");

    a_indiv_apply: assert property ( // RQ4
        wr_data && ch_hit[0] && !strobe_s |=> active_r[0] == $past(din))
        else $error("individual update did not reach channel 0");

    a_simul_hold: assert property ( // RQ5
        strobe_s |=> $stable(active_r))
        else $error("output changed while strobe high");

    a_first_kept: assert property ( // RQ5
        taken_r[1] && strobe_s |=> $stable(pend_r[1]))
        else $error("later write replaced first pending code");

    a_simul_apply: assert property ( // RQ6
        strobe_fall && !wr_data |=> active_r == $past(pend_r))
        else $error("simultaneous update did not load all channels");

    a_ladder_bits: assert property ( // RQ11
        ce |=> ladder_switches[0] == $past(active_r[0][11:0]))
        else $error("ladder switches differ from code lsbs");

    a_seg_therm: assert property ( // RQ10
        ce |=> segment_switches[1] == qcd_therm($past(active_r[1][15:12])))
        else $error("segment switches not thermometer of msbs");

    a_zero_offset: assert property ( // RQ13
        ce && active_r[2] == 16'h0000 && range_r[2] == RANGE_4_20
        |=> channel_current_output[2] == 25'h03D0900)
        else $error("4-20 range zero code is not 4 mA");

    a_full_scale: assert property ( // RQ12
        ce && active_r[1] == 16'hFFFF && range_r[1] == RANGE_0_24
        |=> channel_current_output[1] == 25'h16E3491)
        else $error("0-24 range full scale current wrong");

    a_cal_blocks: assert property ( // RQ9
        frame_end && !cal_done
        |=> $stable(data_r) && $stable(range_r) && $stable(channel_output_en))
        else $error("frame accepted during calibration wait");

    a_cal_count: assert property ( // RQ9
        $rose(cal_done) |-> $past(cal_cnt_r) == CAL_CYCLES - 12'h001)
        else $error("calibration wait ended at wrong count");

    a_ce_freeze: assert property (
        !ce |=> $stable(active_r) && $stable(channel_current_output) && $stable(state_r))
        else $error("state moved while clock enable low");

    a_taken_clear: assert property ( // RQ5
        strobe_rise && !wr_data |=> taken_r == 4'h0)
        else $error("strobe rise did not rearm first write flags");

    c_indiv_write: cover property (wr_data && !strobe_s);
    c_simul_apply: cover property (strobe_fall && (taken_r != 4'h0));
    c_pec_frame:   cover property (wr_data && pec_s);
    c_second_write: cover property (wr_data && strobe_s && taken_r[0] && ch_hit[0]);
    c_range_4_20:   cover property (wr_ctrl && word[RANGE_MSB:RANGE_LSB] == RANGE_4_20);
endmodule
`default_nettype wire

// [sim/qcd_host_model.sv]
// host serial master model driving the three-wire link
`timescale 1ns/10ps
`default_nettype none
module qcd_host_model (
    // serial link
    output var logic sclk,
    output var logic frame_sel_n,
    output var logic sdin
);
    initial begin
        sclk        = 1'b1;
        sdin        = 1'b0;
        // a clean rise of frame select rearms the link counter before any frame
        frame_sel_n = 1'b0;
        #1;
        frame_sel_n = 1'b1;
    end

    // one frame of the low n bits of w, msb first; clock stands still outside frames
    task automatic send(input logic [31:0] w, input int n);
        frame_sel_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            sdin = w[i];
            #24;
            sclk = 1'b0;
            #24;
            sclk = 1'b1;
        end
        #24;
        frame_sel_n = 1'b1;
        // released data line shows the inverse of its last value
        sdin = ~sdin;
        #200;
    endtask

    // clock edges while frame select is high
    task automatic stray(input int n);
        for (int i = 0; i < n; i++) begin
            #24;
            sclk = 1'b0;
            sdin = ~sdin;
            #24;
            sclk = 1'b1;
        end
        #100;
    endtask
endmodule
`default_nettype wire

// [sim/testbench.sv]
// self-checking testbench of the serial load block
`timescale 1ns/10ps
`default_nettype none
module testbench import qcd_pkg::*;;
    logic              mclk = 1'b0;
    logic              rst_n;
    logic              ce;
    logic              strobe;
    logic              pchk;
    wire logic         sclk;
    wire logic         frame_sel_n;
    wire logic         sdin;
    logic              cal_done;
    logic [3:0]        en;
    logic [3:0][14:0]  seg;
    logic [3:0][11:0]  lad;
    logic [3:0][24:0]  cur;
    logic [15:0]       exp_code [4];
    logic [1:0]        exp_rng [4];
    logic [3:0]        exp_en;
    logic [15:0]       code_a;
    logic [15:0]       code_b;
    int                errors = 0;
    int                checks = 0;
    int                n;
    int                c;

    always #20 mclk = ~mclk;

    qcd_serial_load u_qcd_serial_load (
        .mclk                   (mclk),
        .rst_n                  (rst_n),
        .ce                     (ce),
        .sclk                   (sclk),
        .frame_sel_n            (frame_sel_n),
        .sdin                   (sdin),
        .output_update_strobe   (strobe),
        .packet_check           (pchk),
        .cal_done               (cal_done),
        .channel_output_en      (en),
        .segment_switches       (seg),
        .ladder_switches        (lad),
        .channel_current_output (cur)
    );

    qcd_host_model u_qcd_host_model (
        .sclk        (sclk),
        .frame_sel_n (frame_sel_n),
        .sdin        (sdin)
    );

    function automatic logic [14:0] exp_seg(input logic [3:0] m);
        logic [14:0] t;
        for (int k = 0; k < 15; k++) begin
            t[k] = (5'(m) > 5'(k));
        end
        return t;
    endfunction

    // ideal current in nA, floor of span times code over 2^16, plus 4 mA in 4-20
    function automatic logic [24:0] exp_cur(input logic [15:0] d, input logic [1:0] r);
        logic [40:0] p;
        case (r)
            RANGE_0_24: p = 41'(SPAN_24_NA) * 41'(d);
            RANGE_4_20: p = 41'(SPAN_16_NA) * 41'(d);
            default:    p = 41'(SPAN_20_NA) * 41'(d);
        endcase
        p = p >> 16;
        if (r == RANGE_4_20) begin
            p = p + 41'(OFF_4_20_NA);
        end
        return p[24:0];
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic check_all;
        for (int k = 0; k < 4; k++) begin
            check("output_en", 32'(en[k]), 32'(exp_en[k]));
            check("segment_switches", 32'(seg[k]), 32'(exp_seg(exp_code[k][15:12])));
            check("ladder_switches", 32'(lad[k]), 32'(exp_code[k][11:0]));
            check("current", 32'(cur[k]), 32'(exp_cur(exp_code[k], exp_rng[k])));
        end
    endtask

    // data frame, then let the update settle
    task automatic wr(input int ch, input logic [15:0] d, input int bits);
        logic [31:0] w;
        w = {8'h00, CMD_DATA, 3'h0, 2'(ch), d};
        if (bits == 32) begin
            w = {w[23:0], 8'($urandom)};
        end
        u_qcd_host_model.send(w, bits);
        repeat (8) @(negedge mclk);
    endtask

    task automatic tally_and_finish;
        if (errors == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        rst_n  = 1'b0;
        ce     = 1'b1;
        strobe = 1'b0;
        pchk   = 1'b0;
        exp_en = 4'h0;
        for (int k = 0; k < 4; k++) begin
            exp_code[k] = 16'h0000;
            exp_rng[k]  = RANGE_0_20;
        end
        void'($urandom(26));
        repeat (8) @(negedge mclk);
        rst_n = 1'b1;
        @(negedge mclk);
        check_all();
        n = 0;
        while (cal_done !== 1'b1 && n < 3000) begin
            @(negedge mclk);
            n++;
        end
        if (n >= 3000) begin
            errors++;
        end
        // control writes: every range code, outputs enabled
        for (int k = 0; k < 4; k++) begin
            exp_rng[k] = 2'(k);
            exp_en[k]  = 1'b1;
            u_qcd_host_model.send({8'h00, CMD_CTRL, 3'h0, 2'(k), 7'h00, 1'b1, 6'h00, 2'(k)}, 24);
        end
        repeat (8) @(negedge mclk);
        check_all();
        // corner codes, then random codes, one channel at a time
        for (int k = 0; k < 28; k++) begin
            c = (k < 8) ? k % 4 : int'($urandom % 4);
            code_a = (k < 4) ? 16'hFFFF : (k < 8) ? 16'(16'h0FFF << (k - 4)) : 16'($urandom);
            wr(c, code_a, 24);
            exp_code[c] = code_a;
            check_all();
        end
        // unknown command and wrong lengths are dropped
        u_qcd_host_model.send({8'h00, 3'h2, 3'h0, 2'h0, ~exp_code[0]}, 24);
        wr(0, ~exp_code[0], 23);
        wr(0, ~exp_code[0], 25);
        check_all();
        // stray clocks with frame select high, then a clean frame
        u_qcd_host_model.stray(5);
        wr(1, 16'h1000, 24);
        exp_code[1] = 16'h1000;
        check_all();
        // packet check: 32-bit frame taken, 24-bit frame dropped
        pchk = 1'b1;
        repeat (4) @(negedge mclk);
        wr(2, 16'h8001, 32);
        exp_code[2] = 16'h8001;
        wr(2, 16'h7FFE, 24);
        check_all();
        pchk = 1'b0;
        repeat (4) @(negedge mclk);
        // simultaneous update, two rounds
        for (int r = 0; r < 2; r++) begin
            code_a = 16'($urandom);
            code_b = 16'($urandom);
            strobe = 1'b1;
            repeat (4) @(negedge mclk);
            wr(0, code_a, 24);
            wr(0, code_b, 24);
            wr(3, code_b, 24);
            check_all();
            strobe = 1'b0;
            exp_code[0] = code_a;
            exp_code[3] = code_b;
            repeat (8) @(negedge mclk);
            check_all();
        end
        // clock enable low freezes the system domain: a whole frame is lost
        ce = 1'b0;
        wr(2, ~exp_code[2], 24);
        check_all();
        ce = 1'b1;
        repeat (8) @(negedge mclk);
        check_all();
        // reset in mid-run, then a frame inside the calibration wait is dropped
        rst_n = 1'b0;
        repeat (8) @(negedge mclk);
        rst_n  = 1'b1;
        exp_en = 4'h0;
        for (int k = 0; k < 4; k++) begin
            exp_code[k] = CODE_RST;
            exp_rng[k]  = RANGE_RST;
        end
        @(negedge mclk);
        check_all();
        u_qcd_host_model.send({8'h00, CMD_CTRL, 3'h0, 2'h0, 7'h00, 1'b1, 6'h00, RANGE_4_20}, 24);
        repeat (8) @(negedge mclk);
        check("cal_done", 32'(cal_done), 32'h0);
        check_all();
        tally_and_finish();
    end
endmodule
`default_nettype wire
